// ### src/port_cde_io.sv
/*
 * General purpose I/O ports C, D and E with direction registers,
 * port C peripheral override, analog read-as-zero on port E and the
 * microprocessor port mode select.
 * Assumes pins are asynchronous to i_clk and peripherals share i_clk.
 */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module port_cde_io #(
    parameter int SYNC_STAGES = 3
) (
    // Clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    // Register port
    input  wire logic [7:0]                 i_addr,
    input  wire logic [7:0]                 i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [7:0]                 o_rdata,
    // Configuration
    input  wire logic                       i_master_clear_pin_enable,
    // Port C pins and peripheral override
    input  wire logic [7:0]                 i_pc_pin,
    output port_cde_pkg::pin_drive_s        o_pc_drive,
    input  wire port_cde_pkg::periph_ovr_s  i_pc_periph,
    output logic      [7:0]                 o_pc_periph_in,
    // Port D pins
    input  wire logic [7:0]                 i_pd_pin,
    output port_cde_pkg::pin_drive_s        o_pd_drive,
    // Port E pins (bit 3 is input only)
    input  wire logic [3:0]                 i_pe_pin,
    output logic      [2:0]                 o_pe_out,
    output logic      [2:0]                 o_pe_oe,
    // Microprocessor port hand-off
    output logic                            o_parallel_port_select,
    output logic      [2:0]                 o_pe_ctrl_in,
    output logic      [7:0]                 o_pd_pins_in
);

    // Elaboration check: the agreement filter below is built for three stages only
    if (SYNC_STAGES != 3) begin : g_bad_sync_stages
        $error("SYNC_STAGES must be 3");
    end

    // ==========================================================
    // Registers
    logic [7:0] port_c_latch;
    logic [7:0] port_d_latch;
    logic [2:0] port_e_latch;
    logic [7:0] port_c_direction_reg;
    logic [7:0] port_d_direction_reg;
    logic [2:0] port_e_dir_bits;
    logic       parallel_port_select;
    logic       overflow_flag;
    logic [3:0] analog_select_register;

    // Pin synchronisers: three stages, change accepted when 2 and 3 agree
    logic [19:0] sync1;
    logic [19:0] sync2;
    logic [19:0] sync3;
    logic [19:0] pins_clean;
    logic [19:0] pins_raw;

    assign pins_raw = {i_pe_pin, i_pd_pin, i_pc_pin};

    // First stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Filter: hold last value until two late stages agree
    genvar g;
    generate
        for (g = 0; g < 20; g++) begin : g_filt
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pins_clean[g] <= 1'b0;
                end else if (sync2[g] == sync3[g]) begin
                    pins_clean[g] <= sync3[g];
                end
            end
        end
    endgenerate

    logic [7:0] pc_in;
    logic [7:0] pd_in;
    logic [3:0] pe_in;
    assign pc_in = pins_clean[7:0];
    assign pd_in = pins_clean[15:8];
    assign pe_in = pins_clean[19:16];

    // Analog selection of the three port E pins; codes of 7 and above
    // make them digital, so reset (0) leaves them analog as well.
    function automatic logic [2:0] analog_mask(input logic [3:0] cfg);
        analog_mask = (cfg >= 4'h7) ? port_cde_pkg::ANALOG_ALL_DIGITAL : 3'h7;
    endfunction

    logic [2:0] pe_analog;
    assign pe_analog = analog_mask(analog_select_register);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // ==========================================================
    // Data latches: written regardless of direction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_c_latch <= port_cde_pkg::RST_LATCH;
            port_d_latch <= port_cde_pkg::RST_LATCH;
            port_e_latch <= 3'h0;
        end else if (i_wr) begin
            if (hit(i_addr, port_cde_pkg::ADDR_PORT_C_DATA)) port_c_latch <= i_wdata;
            if (hit(i_addr, port_cde_pkg::ADDR_PORT_D_DATA)) port_d_latch <= i_wdata;
            if (hit(i_addr, port_cde_pkg::ADDR_PORT_E_DATA)) port_e_latch <= i_wdata[2:0];
        end
    end

    // Direction registers; all reset types land here through i_rst_n
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_c_direction_reg <= port_cde_pkg::RST_PORT_C_DIR;
            port_d_direction_reg <= port_cde_pkg::RST_PORT_D_DIR;
            port_e_dir_bits      <= port_cde_pkg::RST_PORT_E_DIR[2:0];
            parallel_port_select <= port_cde_pkg::RST_PORT_E_DIR[port_cde_pkg::PE_PARALLEL_SELECT_BIT];
            overflow_flag        <= port_cde_pkg::RST_PORT_E_DIR[port_cde_pkg::PE_OVERFLOW_BIT];
            analog_select_register <= port_cde_pkg::RST_ANALOG_SEL;
        end else if (i_wr) begin
            if (hit(i_addr, port_cde_pkg::ADDR_PORT_C_DIR)) port_c_direction_reg <= i_wdata;
            if (hit(i_addr, port_cde_pkg::ADDR_PORT_D_DIR)) port_d_direction_reg <= i_wdata;
            if (hit(i_addr, port_cde_pkg::ADDR_PORT_E_DIR)) begin
                port_e_dir_bits      <= i_wdata[2:0];
                parallel_port_select <= i_wdata[port_cde_pkg::PE_PARALLEL_SELECT_BIT];
                // Overflow is only cleared by software; nothing in this block or on its ports ever sets the flag
                overflow_flag        <= overflow_flag & i_wdata[port_cde_pkg::PE_OVERFLOW_BIT];
            end
            if (hit(i_addr, port_cde_pkg::ADDR_ANALOG_SEL)) analog_select_register <= i_wdata[3:0];
        end
    end

    // ==========================================================
    // Port C: peripherals may take over any pin
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // Pins 0-2 timer/capture, 3 clock, 4 data, 5 data out, 6-7 UART
            if (i_pc_periph.sel[i]) begin
                pc_out[i] = i_pc_periph.out[i];
                pc_oe[i]  = i_pc_periph.oe[i];
            end else begin
                pc_out[i] = port_c_latch[i];
                pc_oe[i]  = ~port_c_direction_reg[i];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pc_drive <= '{out: 8'h00, oe: 8'h00};
        end else begin
            o_pc_drive <= '{out: pc_out, oe: pc_oe};
        end
    end
    assign o_pc_periph_in = pc_in;

    // ==========================================================
    // Port D: in microprocessor mode direction is ignored and drive is
    // left to the external handshake logic, so pins are released here.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pd_drive <= '{out: 8'h00, oe: 8'h00};
        end else if (parallel_port_select) begin
            o_pd_drive <= '{out: port_d_latch, oe: 8'h00};
        end else begin
            o_pd_drive <= '{out: port_d_latch, oe: ~port_d_direction_reg};
        end
    end
    assign o_pd_pins_in = pd_in;

    // ==========================================================
    // Port E: direction bits rule the drivers even for analog pins
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pe_out <= 3'h0;
            o_pe_oe  <= 3'h0;
        end else begin
            o_pe_out <= port_e_latch;
            o_pe_oe  <= ~port_e_dir_bits;
        end
    end

    // Control inputs for the microprocessor port: idle high outside mode
    assign o_parallel_port_select = parallel_port_select;
    assign o_pe_ctrl_in = parallel_port_select ? pe_in[2:0] : 3'h7;

    // Fourth pin reads only when master clear pin is disabled
    logic pe_fourth;
    assign pe_fourth = i_master_clear_pin_enable ? 1'b0 : pe_in[3];

    // ==========================================================
    // Read port: data one cycle after the strobe
    logic [7:0] next_rdata;
    always_comb begin
        unique case (i_addr)
            port_cde_pkg::ADDR_PORT_C_DATA: next_rdata = pc_in;
            port_cde_pkg::ADDR_PORT_D_DATA: next_rdata = pd_in;
            port_cde_pkg::ADDR_PORT_E_DATA: next_rdata = {4'h0, pe_fourth, pe_in[2:0] & ~pe_analog};
            port_cde_pkg::ADDR_PORT_C_DIR:  next_rdata = port_c_direction_reg;
            port_cde_pkg::ADDR_PORT_D_DIR:  next_rdata = port_d_direction_reg;
            port_cde_pkg::ADDR_PORT_E_DIR:  next_rdata = {2'b00, overflow_flag, parallel_port_select,
                                                          1'b1, port_e_dir_bits};
            port_cde_pkg::ADDR_ANALOG_SEL:  next_rdata = {4'h0, analog_select_register};
            default:                        next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule : port_cde_io

`default_nettype wire

// ### src/port_cde_pkg.sv
/*
 * Constants and carrier types for the port C/D/E I/O block: register
 * offsets, reset values, field positions and pin bundles.
 * Assumes a single 50 MHz core clock and an 8-bit register port.
 */
// Notes on behaviour
// - Port D has eight pins, each with its own direction bit.
// - Parallel port select set makes port D an 8-bit microprocessor data port.
// - Port E has four pins; lower three have separate direction bits.
// - Fourth port E pin is a general input only when master clear pin is disabled.
// - Fourth pin is input only; its direction bit reads one and does nothing.
// - With parallel port select set, lower port E pins are read, write, chip select.
// - Port E pins selected as analog inputs read as zero.
// - Direction bits still drive analog pins; software keeps them inputs.
// - Power-on reset leaves port E pins analog, reading zero.
// - Port D direction resets to all ones on every reset.
// - Port E direction register resets to 0000 1111 on every reset.
// - Port C pin 3 can be the serial peripheral clock.
// - Port C pin 4 can be serial data in or two-way data.
// - Port C pin 5 can be the serial data output.
// - Port C pins 6 and 7 can be UART transmit and receive or clock and data.
// - Port C pins 0 to 2 shared with secondary timer and capture units.
// - Direction one makes a pin input; zero drives the output latch.

`default_nettype none

package port_cde_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_PORT_C_DATA = 8'h07;
    localparam logic [7:0] ADDR_PORT_D_DATA = 8'h08;
    localparam logic [7:0] ADDR_PORT_E_DATA = 8'h09;
    localparam logic [7:0] ADDR_PORT_C_DIR  = 8'h87;
    localparam logic [7:0] ADDR_PORT_D_DIR  = 8'h88;
    localparam logic [7:0] ADDR_PORT_E_DIR  = 8'h89;
    localparam logic [7:0] ADDR_ANALOG_SEL  = 8'h9F;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_PORT_C_DIR  = 8'hFF;
    localparam logic [7:0] RST_PORT_D_DIR  = 8'hFF;
    localparam logic [7:0] RST_PORT_E_DIR  = 8'h0F;
    localparam logic [3:0] RST_ANALOG_SEL  = 4'h0;
    localparam logic [2:0] ANALOG_ALL_DIGITAL = 3'h0;
    localparam logic [7:0] RST_LATCH       = 8'h00;

    // ==========================================================
    // Field positions in the port E direction register
    localparam int PE_PARALLEL_SELECT_BIT = 4;
    localparam int PE_OVERFLOW_BIT        = 5;
    localparam int PE_FOURTH_DIR_BIT      = 3;

    // ==========================================================
    // Pin and peripheral carriers
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_s;

    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] out;
        logic [7:0] oe;
    } periph_ovr_s;

endpackage : port_cde_pkg

`default_nettype wire

// ### test/port_cde_io_monitor.sv
/* Checker for port_cde_io, bound to every instance of it.
   Assumes reads answer one edge later and pad drives lag a write by two edges. */
`timescale 1ns/1ps
`default_nettype none
module port_cde_io_monitor (
    // Clock, reset and register port
    input wire logic                      i_clk,
    input wire logic                      i_rst_n,
    input wire logic [7:0]                i_addr,
    input wire logic [7:0]                i_wdata,
    input wire logic                      i_wr,
    input wire logic                      i_rd,
    input wire logic [7:0]                o_rdata,
    // Pads and configuration
    input wire logic                      i_master_clear_pin_enable,
    input wire logic [7:0]                i_pc_pin,
    input wire port_cde_pkg::periph_ovr_s i_pc_periph,
    input wire logic [7:0]                o_pc_periph_in,
    input wire port_cde_pkg::pin_drive_s  o_pc_drive,
    input wire port_cde_pkg::pin_drive_s  o_pd_drive,
    input wire logic [2:0]                o_pe_oe,
    input wire logic                      o_parallel_port_select
);
    // ==========
    // One clock domain, so one clocking and one disable for all
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_rd_slot: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data seen outside its slot");
    chk_dir_e_read: assert property (i_rd && i_addr == 8'h89 |=> o_rdata[3] && o_rdata[7:6] == 2'h0)
        else $error("port E direction read back wrong");
    chk_rst_gate: assert property (i_rd && i_addr == 8'h09 && i_master_clear_pin_enable
        |=> o_rdata[7:3] == 5'h00) else $error("input only pin leaked while reset pin enabled");
    chk_pd_dir: assert property (i_wr && i_addr == 8'h88
        |-> ##2 (o_parallel_port_select || o_pd_drive.oe == ~$past(i_wdata, 2))) else $error("port D drive mismatch");
    chk_pe_dir: assert property (i_wr && i_addr == 8'h89
        |-> ##2 (o_pe_oe == ~$past(i_wdata[2:0], 2))) else $error("port E drive mismatch");
    chk_par_float: assert property (o_parallel_port_select && $past(o_parallel_port_select)
        |-> o_pd_drive.oe == 8'h00) else $error("port D driven in parallel mode");
    chk_periph_ovr: assert property (i_rst_n && i_pc_periph.sel == 8'hFF
        |=> o_pc_drive == {$past(i_pc_periph.out), $past(i_pc_periph.oe)}) else $error("override not applied");
    chk_pin_sync: assert property (!$stable(i_pc_pin) ##1 $stable(i_pc_pin) [*5]
        |-> o_pc_periph_in == i_pc_pin) else $error("port C levels not synchronised");
    // Main scenarios reached
    cover property (o_parallel_port_select);
    cover property (i_pc_periph.sel == 8'hFF);
    cover property (i_rd && i_addr == 8'h55);
    cover property (i_rd && i_addr == 8'h09 && i_master_clear_pin_enable);
endmodule : port_cde_io_monitor
bind port_cde_io port_cde_io_monitor u_port_cde_io_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pc_pin(i_pc_pin),
    .i_master_clear_pin_enable(i_master_clear_pin_enable), .i_pc_periph(i_pc_periph),
    .o_pc_periph_in(o_pc_periph_in), .o_pc_drive(o_pc_drive), .o_pd_drive(o_pd_drive), .o_pe_oe(o_pe_oe),
    .o_parallel_port_select(o_parallel_port_select));
`default_nettype wire

// ### test/pin_board.sv
/* Board model on the pads of ports C, D and E.
   Assumes the bench supplies the levels that outside parts put on released pads. */
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    // Drives from the block
    input wire port_cde_pkg::pin_drive_s i_pc_drive,
    input wire port_cde_pkg::pin_drive_s i_pd_drive,
    input wire logic [2:0]               i_pe_out,
    input wire logic [2:0]               i_pe_oe,
    // Outside levels, changed on every pass of the random traffic test
    input wire logic [7:0]               i_c_ext,
    input wire logic [7:0]               i_d_ext,
    input wire logic [3:0]               i_e_ext,
    // Resolved pad levels
    output logic     [7:0]               o_c,
    output logic     [7:0]               o_d,
    output logic     [3:0]               o_e
);
    // A driving pad wins; a released pad shows the outside level, never a stale one
    assign o_c = (i_pc_drive.oe & i_pc_drive.out) | (~i_pc_drive.oe & i_c_ext);
    assign o_d = (i_pd_drive.oe & i_pd_drive.out) | (~i_pd_drive.oe & i_d_ext);
    assign o_e = {i_e_ext[3], (i_pe_oe & i_pe_out) | (~i_pe_oe & i_e_ext[2:0])};
endmodule : pin_board
`default_nettype wire

// ### test/ports_c_d_e_io_control_tb.sv
/* Self-checking bench for port_cde_io against a register model.
   Assumes pin_board on the pads and a settled read four edges after a pin change. */
`timescale 1ns/1ps
`default_nettype none
module ports_c_d_e_io_control_tb;
    // ==========
    // Signals, model state and counters
    localparam logic [7:0] ADDRS [8] = '{8'h07, 8'h08, 8'h09, 8'h87, 8'h88, 8'h89, 8'h9F, 8'h55};
    logic                      clk, rst_n, wr, rd, mce, psel;
    logic [7:0]                addr, wdata, rdata, c_ext, d_ext, pc_pin, pd_pin, pc_in, pd_in;
    logic [7:0]                lat_c, lat_d, dir_c, dir_d;
    logic [3:0]                e_ext, pe_pin, dir_e, code;
    logic [2:0]                pe_out, pe_oe, ctrl_in, lat_e;
    port_cde_pkg::pin_drive_s  pc_drv, pd_drv;
    port_cde_pkg::periph_ovr_s pov;
    int                        n_mismatch, check_count;
    port_cde_io u_port_cde_io (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_master_clear_pin_enable(mce), .i_pc_pin(pc_pin), .o_pc_drive(pc_drv),
        .i_pc_periph(pov), .o_pc_periph_in(pc_in), .i_pd_pin(pd_pin), .o_pd_drive(pd_drv), .i_pe_pin(pe_pin),
        .o_pe_out(pe_out), .o_pe_oe(pe_oe), .o_parallel_port_select(psel), .o_pe_ctrl_in(ctrl_in),
        .o_pd_pins_in(pd_in));
    pin_board u_pin_board (.i_pc_drive(pc_drv), .i_pd_drive(pd_drv), .i_pe_out(pe_out), .i_pe_oe(pe_oe),
        .i_c_ext(c_ext), .i_d_ext(d_ext), .i_e_ext(e_ext), .o_c(pc_pin), .o_d(pd_pin), .o_e(pe_pin));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========
    // Compare, bus tasks and the expected read value
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        case (a)
            8'h07: lat_c = d;
            8'h08: lat_d = d;
            8'h09: lat_e = d[2:0];
            8'h87: dir_c = d;
            8'h88: dir_d = d;
            8'h89: dir_e = {d[4], d[2:0]};
            8'h9F: code = d[3:0];
            default: ;
        endcase
    endtask : write
    task automatic read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 compare(rdata, exp);
    endtask : read
    // Pads as the rules put them, periph override first; analog pins read zero
    function automatic logic [7:0] expect_of(input logic [7:0] a);
        logic [7:0] cp;
        logic [2:0] ep;
        cp = (pov.sel & ((pov.oe & pov.out) | (~pov.oe & c_ext))) | (~pov.sel & ((~dir_c & lat_c) | (dir_c & c_ext)));
        ep = (~dir_e[2:0] & lat_e) | (dir_e[2:0] & e_ext[2:0]);
        case (a)
            8'h07: return cp;
            8'h08: return (~dir_d & lat_d) | (dir_d & d_ext);
            8'h09: return {4'h0, ~mce & e_ext[3], (code >= 4'h7) ? ep : 3'h0};
            8'h87: return dir_c;
            8'h88: return dir_d;
            8'h89: return {3'h0, dir_e[3], 1'b1, dir_e[2:0]};
            8'h9F: return {4'h0, code};
            default: return 8'h00;
        endcase
    endfunction : expect_of
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // ==========
    // Main sequence
    initial begin : main
        logic [7:0] a, d;
        {rst_n, wr, rd, mce, addr, wdata, pov, lat_c, lat_d, lat_e, code} = '0;
        {c_ext, d_ext, e_ext, dir_c, dir_d, dir_e} = {8'h3C, 8'h5A, 4'hF, 8'hFF, 8'hFF, 4'h7};
        void'($urandom(32'hEE48));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        read(8'h87, 8'hFF);
        read(8'h88, 8'hFF);
        read(8'h89, 8'h0F);
        read(8'h09, 8'h08);
        read(8'h55, 8'h00);
        $display("test reset values done");
        for (int k = 0; k < 40; k++) begin
            a = ADDRS[$urandom % 8];
            d = (a == 8'h89) ? (8'($urandom) & 8'hCF) : (a == 8'h9F) ? (8'($urandom) & 8'h0F) : 8'($urandom);
            @(posedge clk);
            {c_ext, d_ext, e_ext} <= 20'($urandom);
            mce <= 1'($urandom);
            pov <= {(k % 3 == 0) ? 8'hFF : 8'($urandom), 16'($urandom)};
            write(a, d);
            repeat (6) @(posedge clk);
            #1 compare(pd_drv.out, lat_d);
            compare(pc_in, expect_of(8'h07));
            foreach (ADDRS[j]) read(ADDRS[j], expect_of(ADDRS[j]));
        end
        $display("test random traffic done");
        // Second reset in mid-run: i_rst_n must restore the port D and port E directions
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        {lat_c, lat_d, lat_e, code, dir_c, dir_d, dir_e} = {8'h00, 8'h00, 3'h0, 4'h0, 8'hFF, 8'hFF, 4'h7};
        repeat (6) @(posedge clk);
        read(8'h88, 8'hFF);
        read(8'h89, 8'h0F);
        read(8'h09, expect_of(8'h09));
        $display("test second reset done");
        write(8'h9F, 8'h0F);
        write(8'h88, 8'h00);
        write(8'h89, 8'h17);
        repeat (6) @(posedge clk);
        #1 compare({7'h00, psel}, 8'h01);
        compare(pd_drv.oe, 8'h00);
        compare(pd_in, d_ext);
        compare({5'h00, ctrl_in}, {5'h00, e_ext[2:0]});
        write(8'h89, 8'h07);
        repeat (6) @(posedge clk);
        #1 compare({5'h00, ctrl_in}, 8'h07);
        $display("test parallel mode done");
        conclude();
    end
endmodule : ports_c_d_e_io_control_tb
`default_nettype wire
